// >>> core/aamd_datapath.sv
// accumulator datapath for move, arithmetic, logic, swap and exchange
// Functional notes
// - literal load to bank zero only hits 0x80..0x87, one cycle, flags kept
// - table read: rom[y:z] low byte to acc, high byte to r, two cycles
// - add with carry sums acc, memory and carry; updates c, dc, z
// - plain add of memory or literal; carry out; acc form one cycle
// - subtract with borrow: acc minus memory minus inverted carry
// - subtract memory; one cycle to acc, 1+N to memory
// - subtract literal into acc in one cycle; c is not-borrow
// - bank zero add writes acc plus memory back, 1+N cycles
// - and, or, xor update only zero; 1 to acc, 1+N to memory
// - nibble swap to acc in one cycle or memory in 1+N, no flags
// - exchange acc with memory, current or bank zero, 1+N, no flags
// - N is zero for system registers, one for general ram
`timescale 1ns/1ps
`default_nettype none
module aamd_datapath #(
    parameter int ROM_AW = 16
) (
    input  wire logic                   clk_i,        // core clock
    input  wire logic                   rst_b_i,      // async reset, low
    input  wire logic                   ce_i,         // clock enable
    input  wire logic                   req_valid_i,  // request strobe
    input  wire aamd_pkg::aamd_req_s    req_i,        // request fields
    input  wire logic [7:0]             y_i,          // table pointer high
    input  wire logic [7:0]             z_i,          // table pointer low
    input  wire logic [15:0]            rom_data_i,   // program word
    output logic                        busy_o,       // second cycle pending
    output logic      [ROM_AW-1:0]      rom_addr_o,   // program address
    output logic                        mem_we_o,     // memory write pulse
    output logic      [7:0]             mem_addr_o,   // memory write address
    output logic                        mem_b0_o,     // write is bank zero
    output logic      [7:0]             mem_wdata_o,  // memory write data
    output logic      [7:0]             acc_o,        // accumulator
    output logic      [7:0]             r_o,          // r register
    output logic                        r_we_o,       // r written pulse
    output var aamd_pkg::aamd_flags_s   flags_o,      // c, dc, z
    output logic      [1:0]             cycles_o,     // cycles of last op
    output logic                        done_o        // last op retired
);
    initial begin
        if (ROM_AW < 1 || ROM_AW > 16) $error("ROM_AW must be 1..16");
    end

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    typedef enum logic {AAMD_IDLE, AAMD_TABLE2} aamd_state_e;
    aamd_state_e state;

    // extra cycle for general ram operands
    function automatic logic [1:0] extra_n(input logic [7:0] addr);
        return (addr <= aamd_pkg::SYSREG_LAST) ? aamd_pkg::EXTRA_SYSREG
                                               : aamd_pkg::EXTRA_RAM;
    endfunction

    aamd_pkg::aamd_op_e op;
    logic [7:0] opnd;
    logic       take;
    logic       is_arith, is_carry_in, is_sub, is_logic, is_mem_dst;
    logic [1:0] lop;
    assign op   = req_i.op;
    assign take = ce_i && req_valid_i && (state == AAMD_IDLE);

    always_comb begin
        is_arith    = 1'b0;
        is_carry_in = 1'b0;
        is_sub      = 1'b0;
        is_logic    = 1'b0;
        is_mem_dst  = 1'b0;
        lop         = 2'h3;
        opnd        = req_i.mem;
        case (op)
            aamd_pkg::AAMD_OP_ADC_AM:   begin is_arith = 1'b1; is_carry_in = 1'b1; end
            aamd_pkg::AAMD_OP_ADC_MA:   begin is_arith = 1'b1; is_carry_in = 1'b1;
                                              is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_ADD_AM:   is_arith = 1'b1;
            aamd_pkg::AAMD_OP_ADD_MA,
            aamd_pkg::AAMD_OP_BANK_ZERO_ADD_TO_MEMORY_MA: begin is_arith = 1'b1; is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_ADD_AI:   begin is_arith = 1'b1; opnd = req_i.lit; end
            aamd_pkg::AAMD_OP_SBC_AM:   begin is_arith = 1'b1; is_sub = 1'b1;
                                              is_carry_in = 1'b1; end
            aamd_pkg::AAMD_OP_SBC_MA:   begin is_arith = 1'b1; is_sub = 1'b1;
                                              is_carry_in = 1'b1; is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_SUB_AM:   begin is_arith = 1'b1; is_sub = 1'b1; end
            aamd_pkg::AAMD_OP_SUB_MA:   begin is_arith = 1'b1; is_sub = 1'b1;
                                              is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_SUB_AI:   begin is_arith = 1'b1; is_sub = 1'b1;
                                              opnd = req_i.lit; end
            aamd_pkg::AAMD_OP_AND_AM:   begin is_logic = 1'b1; lop = 2'h0; end
            aamd_pkg::AAMD_OP_AND_MA:   begin is_logic = 1'b1; lop = 2'h0;
                                              is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_AND_AI:   begin is_logic = 1'b1; lop = 2'h0;
                                              opnd = req_i.lit; end
            aamd_pkg::AAMD_OP_OR_AM:    begin is_logic = 1'b1; lop = 2'h1; end
            aamd_pkg::AAMD_OP_OR_MA:    begin is_logic = 1'b1; lop = 2'h1;
                                              is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_OR_AI:    begin is_logic = 1'b1; lop = 2'h1;
                                              opnd = req_i.lit; end
            aamd_pkg::AAMD_OP_XOR_AM:   begin is_logic = 1'b1; lop = 2'h2; end
            aamd_pkg::AAMD_OP_XOR_MA:   begin is_logic = 1'b1; lop = 2'h2;
                                              is_mem_dst = 1'b1; end
            aamd_pkg::AAMD_OP_XOR_AI:   begin is_logic = 1'b1; lop = 2'h2;
                                              opnd = req_i.lit; end
            aamd_pkg::AAMD_OP_NIBBLE_EXCHANGE_IN_MEMORY:    is_mem_dst = 1'b1;
            default:                    ;
        endcase
    end

    // ------------------------------------------------------------------
    // alu
    // ------------------------------------------------------------------
    logic [7:0] sum, logr;
    logic       cout, hc, cin;
    assign cin = is_carry_in ? flags_o.c : is_sub;
    aamd_alu #(.WIDTH(8)) u_alu (
        .a_i    (acc_o),
        .b_i    (opnd),
        .cin_i  (cin),
        .sub_i  (is_sub),
        .lop_i  (lop),
        .sum_o  (sum),
        .cout_o (cout),
        .hc_o   (hc),
        .log_o  (logr)
    );

    // ------------------------------------------------------------------
    // sequencing: table read takes a second cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= AAMD_IDLE;
        end else if (ce_i) begin
            case (state)
                AAMD_IDLE:   if (take && op == aamd_pkg::AAMD_OP_TABLE_READ)
                                 state <= AAMD_TABLE2;
                AAMD_TABLE2: state <= AAMD_IDLE;
                default:     state <= AAMD_IDLE;
            endcase
        end
    end
    assign busy_o     = (state == AAMD_TABLE2);
    assign rom_addr_o = ROM_AW'({y_i, z_i});

    // ------------------------------------------------------------------
    // accumulator and r
    // ------------------------------------------------------------------
    logic [7:0] next_acc;
    logic       acc_we;
    always_comb begin
        acc_we   = 1'b0;
        next_acc = acc_o;
        if (take && !is_mem_dst) begin
            acc_we = 1'b1;
            case (op)
                aamd_pkg::AAMD_OP_MOV_AM,
                aamd_pkg::AAMD_OP_XCH:    next_acc = req_i.mem;
                aamd_pkg::AAMD_OP_MOV_AI: next_acc = req_i.lit;
                aamd_pkg::AAMD_OP_SWAP:   next_acc = logr;
                default: begin
                    if (is_arith)      next_acc = sum;
                    else if (is_logic) next_acc = logr;
                    else               acc_we   = 1'b0;
                end
            endcase
        end else if (ce_i && busy_o) begin
            acc_we   = 1'b1;
            next_acc = rom_data_i[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_o <= aamd_pkg::ACC_RESET;
        end else if (acc_we) begin
            acc_o <= next_acc;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r_o    <= 8'h00;
            r_we_o <= 1'b0;
        end else if (ce_i) begin
            r_we_o <= busy_o;
            if (busy_o) r_o <= rom_data_i[15:8];
        end
    end

    // ------------------------------------------------------------------
    // flags: untouched unless the op lists them
    // ------------------------------------------------------------------
    logic [7:0] zres;
    logic       zero_upd;
    assign zres     = is_arith ? sum : (is_logic ? logr : req_i.mem);
    assign zero_upd = is_arith || is_logic
                   || (op == aamd_pkg::AAMD_OP_MOV_AM);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_o <= aamd_pkg::FLAGS_RESET;
        end else if (take) begin
            if (is_arith) begin
                flags_o.c  <= cout;
                flags_o.dc <= hc;
            end
            if (zero_upd) flags_o.z <= (zres == 8'h00);
        end
    end

    // ------------------------------------------------------------------
    // memory write, cycle count and retire
    // ------------------------------------------------------------------
    logic       b0_ok;
    assign b0_ok = (req_i.addr >= aamd_pkg::B0_LIT_LO)
                && (req_i.addr <= aamd_pkg::B0_LIT_HI);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mem_we_o    <= 1'b0;
            mem_addr_o  <= 8'h00;
            mem_b0_o    <= 1'b0;
            mem_wdata_o <= 8'h00;
            cycles_o    <= 2'h0;
            done_o      <= 1'b0;
        end else if (ce_i) begin
            mem_we_o <= 1'b0;
            done_o   <= busy_o;
            if (busy_o) cycles_o <= aamd_pkg::TABLE_CYCLES;
            if (take) begin
                mem_addr_o <= req_i.addr;
                mem_b0_o   <= req_i.bank_zero
                           || op == aamd_pkg::AAMD_OP_BANK_ZERO_ADD_TO_MEMORY_MA
                           || op == aamd_pkg::AAMD_OP_BANK_ZERO_MOVE_MI;
                cycles_o   <= aamd_pkg::BASE_CYCLES;
                done_o     <= (op != aamd_pkg::AAMD_OP_TABLE_READ);
                if (is_mem_dst || op == aamd_pkg::AAMD_OP_XCH)
                    cycles_o <= aamd_pkg::BASE_CYCLES
                              + extra_n(req_i.addr);
                case (op)
                    aamd_pkg::AAMD_OP_MOV_MA,
                    aamd_pkg::AAMD_OP_XCH: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= acc_o;
                    end
                    aamd_pkg::AAMD_OP_BANK_ZERO_MOVE_MI: begin
                        mem_we_o    <= b0_ok;
                        mem_wdata_o <= req_i.lit;
                    end
                    default: begin
                        mem_we_o    <= is_mem_dst;
                        mem_wdata_o <= is_arith ? sum : logr;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    b0_window_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        mem_we_o && mem_b0_o && $past(req_i.op) == aamd_pkg::AAMD_OP_BANK_ZERO_MOVE_MI
        |-> mem_addr_o >= 8'h80 && mem_addr_o <= 8'h87)
        else $error("literal load outside window");
    table_two_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        busy_o && ce_i |=> done_o && cycles_o == 2'h2 && r_we_o)
        else $error("table read not two cycles");
    logic_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && is_logic |=> $stable(flags_o.c) && $stable(flags_o.dc))
        else $error("logic op touched carry");
    swap_flags_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && (op == aamd_pkg::AAMD_OP_SWAP || op == aamd_pkg::AAMD_OP_XCH)
        |=> $stable(flags_o))
        else $error("swap or exchange changed flags");
    xch_data_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && op == aamd_pkg::AAMD_OP_XCH
        |=> acc_o == $past(req_i.mem) && mem_wdata_o == $past(acc_o))
        else $error("exchange data wrong");
    ram_cycles_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && is_mem_dst && req_i.addr > 8'h7F |=> cycles_o == 2'h2)
        else $error("ram operand not 1+1 cycles");
    sys_cycles_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && is_mem_dst && req_i.addr <= 8'h7F |=> cycles_o == 2'h1)
        else $error("system register operand not one cycle");
    sub_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && op == aamd_pkg::AAMD_OP_SUB_AI
        |=> flags_o.c == ($past(acc_o) >= $past(req_i.lit)))
        else $error("subtract carry not not-borrow");
    add_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && op == aamd_pkg::AAMD_OP_ADD_AI
        |=> flags_o.c == ({1'b0, $past(acc_o)} + {1'b0, $past(req_i.lit)} > 9'h0FF))
        else $error("add carry wrong");
endmodule
`default_nettype wire

// >>> core/aamd_pkg.sv
// package: opcodes, flag carrier and timing constants for the datapath
package aamd_pkg;

    // ------------------------------------------------------------------
    // operations taken from the sequencer
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        AAMD_OP_NONE,
        AAMD_OP_MOV_AM,       // a <- m
        AAMD_OP_MOV_MA,       // m <- a
        AAMD_OP_MOV_AI,       // a <- literal
        AAMD_OP_BANK_ZERO_MOVE_MI,     // bank zero m <- literal
        AAMD_OP_XCH,          // a <-> m
        AAMD_OP_TABLE_READ,   // r,a <- rom[y,z]
        AAMD_OP_ADC_AM,
        AAMD_OP_ADC_MA,
        AAMD_OP_ADD_AM,
        AAMD_OP_ADD_MA,
        AAMD_OP_ADD_AI,
        AAMD_OP_BANK_ZERO_ADD_TO_MEMORY_MA,
        AAMD_OP_SBC_AM,
        AAMD_OP_SBC_MA,
        AAMD_OP_SUB_AM,
        AAMD_OP_SUB_MA,
        AAMD_OP_SUB_AI,
        AAMD_OP_AND_AM,
        AAMD_OP_AND_MA,
        AAMD_OP_AND_AI,
        AAMD_OP_OR_AM,
        AAMD_OP_OR_MA,
        AAMD_OP_OR_AI,
        AAMD_OP_XOR_AM,
        AAMD_OP_XOR_MA,
        AAMD_OP_XOR_AI,
        AAMD_OP_SWAP,         // a <- nibble swapped m
        AAMD_OP_NIBBLE_EXCHANGE_IN_MEMORY         // m <- nibble swapped m
    } aamd_op_e;

    // ------------------------------------------------------------------
    // request and flag carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        aamd_op_e   op;        // operation code
        logic [7:0] addr;      // memory operand address
        logic       bank_zero; // operand forced to bank zero
        logic [7:0] mem;       // memory operand value
        logic [7:0] lit;       // immediate literal
    } aamd_req_s;

    typedef struct packed {
        logic c;   // carry, not-borrow on subtract
        logic dc;  // half-carry
        logic z;   // zero
    } aamd_flags_s;

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [7:0]  B0_LIT_LO     = 8'h80; // literal load window
    localparam logic [7:0]  B0_LIT_HI     = 8'h87;
    localparam logic [7:0]  SYSREG_LAST   = 8'h7F; // system registers below
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [2:0]  FLAGS_RESET   = 3'h0;
    localparam logic [1:0]  BASE_CYCLES   = 2'h1;
    localparam logic [1:0]  TABLE_CYCLES  = 2'h2;
    localparam logic [1:0]  EXTRA_RAM     = 2'h1;
    localparam logic [1:0]  EXTRA_SYSREG  = 2'h0;

endpackage

// >>> core/aamd_alu.sv
// alu: add, subtract, logic and nibble swap with carry and half-carry
`timescale 1ns/1ps
`default_nettype none
module aamd_alu #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] a_i,     // accumulator operand
    input  wire logic [WIDTH-1:0] b_i,     // memory or literal operand
    input  wire logic             cin_i,   // carry in
    input  wire logic             sub_i,   // subtract, cin is not-borrow
    input  wire logic [1:0]       lop_i,   // 0 and, 1 or, 2 xor, 3 swap
    output logic      [WIDTH-1:0] sum_o,   // arithmetic result
    output logic                  cout_o,  // carry out
    output logic                  hc_o,    // half-carry out
    output logic      [WIDTH-1:0] log_o    // logic result
);
    initial begin
        if (WIDTH != 8) $error("aamd_alu supports only 8 bits");
    end

    logic [WIDTH-1:0] b_eff;
    logic [4:0]       lo_sum;
    logic [WIDTH:0]   full_sum;

    // subtract is add of inverted operand, carry acting as not-borrow
    assign b_eff    = sub_i ? ~b_i : b_i;
    assign lo_sum   = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_i};
    assign full_sum = {1'b0, a_i} + {1'b0, b_eff} + {{WIDTH{1'b0}}, cin_i};
    assign sum_o    = full_sum[WIDTH-1:0];
    assign cout_o   = full_sum[WIDTH];
    assign hc_o     = lo_sum[4];

    // logic and swap unit
    always_comb begin
        case (lop_i)
            2'h0:    log_o = a_i & b_i;
            2'h1:    log_o = a_i | b_i;
            2'h2:    log_o = a_i ^ b_i;
            default: log_o = {b_i[3:0], b_i[7:4]};
        endcase
    end
endmodule
`default_nettype wire

// >>> dv/aamd_mem_model.sv
// partner model: program rom and data memory beside the datapath
`timescale 1ns/1ps
`default_nettype none
module aamd_mem_model (
    input  wire logic        clk_i,       // core clock
    input  wire logic        busy_i,      // table read fetch cycle
    input  wire logic [15:0] rom_addr_i,  // program address
    input  wire logic        mem_we_i,    // memory write pulse
    input  wire logic [7:0]  mem_addr_i,  // write address
    input  wire logic        mem_b0_i,    // write goes to bank zero
    input  wire logic [7:0]  mem_wdata_i, // write data
    output logic      [15:0] rom_data_o   // program word
);
    // ------------------------------------------------------------------
    // program rom and data memory
    // ------------------------------------------------------------------
    logic [15:0] word;
    logic [7:0]  ram [0:511];
    // word is only valid in the fetch cycle, inverted otherwise
    assign word = {rom_addr_i[7:0] ^ 8'h5A, rom_addr_i[15:8] ^ 8'hC3};
    assign rom_data_o = busy_i ? word : ~word;
    // data memory, bank zero in the upper half
    always_ff @(posedge clk_i) begin
        if (mem_we_i) begin
            ram[{mem_b0_i, mem_addr_i}] <= mem_wdata_i;
        end
    end
endmodule
`default_nettype wire

// >>> dv/accumulator_alu_move_datapath_tb.sv
// testbench: table of datapath operations, then table read, stalls, reset
`timescale 1ns/1ps
`default_nettype none
module accumulator_alu_move_datapath_tb;
    // ------------------------------------------------------------------
    // signals and operation table
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] op; logic [7:0] addr; logic b0; logic [7:0] mem;
        logic [7:0] lit; logic [7:0] acc; logic we; logic [7:0] wd;
        logic [2:0] fl; logic [1:0] cyc;
    } aamd_row_s;
    logic                  clk_i       = 1'h0;
    logic                  rst_b_i     = 1'h0;
    logic                  ce_i        = 1'h1;
    logic                  req_valid_i = 1'h0;
    aamd_pkg::aamd_req_s   req_i       = '0;
    logic [7:0]            y_i         = 8'h12;
    logic [7:0]            z_i         = 8'h34;
    logic [15:0]           rom_data_i;
    logic [15:0]           rom_addr_o;
    logic                  busy_o, mem_we_o, mem_b0_o, r_we_o, done_o;
    logic [7:0]            mem_addr_o, mem_wdata_o, acc_o, r_o;
    aamd_pkg::aamd_flags_s flags_o;
    logic [1:0]            cycles_o;
    int                    n_mismatch  = 0;
    int                    tests_run   = 0;
    int                    cyc_count   = 0;
    int                    i;
    // op addr b0 mem lit | acc we wdata flags{c,dc,z} cycles
    aamd_row_s rows [0:28] = '{
    '{5'h03,8'h00,1'h0,8'h00,8'hF0,8'hF0,1'h0,8'h00,3'h0,2'h1},
    '{5'h0B,8'h00,1'h0,8'h00,8'h10,8'h00,1'h0,8'h00,3'h5,2'h1},
    '{5'h07,8'h90,1'h0,8'h0F,8'h00,8'h10,1'h0,8'h00,3'h2,2'h1},
    '{5'h11,8'h00,1'h0,8'h00,8'h11,8'hFF,1'h0,8'h00,3'h0,2'h1},
    '{5'h0D,8'h20,1'h0,8'h0F,8'h00,8'hEF,1'h0,8'h00,3'h4,2'h1},
    '{5'h10,8'h90,1'h0,8'hEF,8'h00,8'hEF,1'h1,8'h00,3'h7,2'h2},
    '{5'h0A,8'h10,1'h0,8'h01,8'h00,8'hEF,1'h1,8'hF0,3'h2,2'h1},
    '{5'h14,8'h00,1'h0,8'h00,8'h0F,8'h0F,1'h0,8'h00,3'h2,2'h1},
    '{5'h16,8'h90,1'h0,8'hF0,8'h00,8'h0F,1'h1,8'hFF,3'h2,2'h2},
    '{5'h18,8'h00,1'h0,8'h0F,8'h00,8'h00,1'h0,8'h00,3'h3,2'h1},
    '{5'h1A,8'h00,1'h0,8'h00,8'h3C,8'h3C,1'h0,8'h00,3'h2,2'h1},
    '{5'h13,8'h05,1'h0,8'hC3,8'h00,8'h3C,1'h1,8'h00,3'h3,2'h1},
    '{5'h15,8'h00,1'h0,8'h00,8'h00,8'h3C,1'h0,8'h00,3'h2,2'h1},
    '{5'h12,8'h00,1'h0,8'h0F,8'h00,8'h0C,1'h0,8'h00,3'h2,2'h1},
    '{5'h17,8'h00,1'h0,8'h00,8'h00,8'h0C,1'h0,8'h00,3'h2,2'h1},
    '{5'h19,8'h90,1'h0,8'h0C,8'h00,8'h0C,1'h1,8'h00,3'h3,2'h2},
    '{5'h1B,8'h00,1'h0,8'hA5,8'h00,8'h5A,1'h0,8'h00,3'h3,2'h1},
    '{5'h1C,8'h90,1'h0,8'h12,8'h00,8'h5A,1'h1,8'h21,3'h3,2'h2},
    '{5'h05,8'h90,1'h0,8'h77,8'h00,8'h77,1'h1,8'h5A,3'h3,2'h2},
    '{5'h04,8'h87,1'h1,8'h00,8'h33,8'h77,1'h1,8'h33,3'h3,2'h1},
    '{5'h04,8'h88,1'h1,8'h00,8'h44,8'h77,1'h0,8'h00,3'h3,2'h1},
    '{5'h0C,8'h90,1'h1,8'h89,8'h00,8'h77,1'h1,8'h00,3'h7,2'h2},
    '{5'h08,8'h90,1'h0,8'h00,8'h00,8'h77,1'h1,8'h78,3'h0,2'h2},
    '{5'h0E,8'h40,1'h0,8'h78,8'h00,8'h77,1'h1,8'hFE,3'h0,2'h1},
    '{5'h0F,8'h00,1'h0,8'h77,8'h00,8'h00,1'h0,8'h00,3'h7,2'h1},
    '{5'h01,8'h00,1'h0,8'h80,8'h00,8'h80,1'h0,8'h00,3'h6,2'h1},
    '{5'h02,8'h90,1'h0,8'h00,8'h00,8'h80,1'h1,8'h80,3'h6,2'h1},
    '{5'h09,8'h00,1'h0,8'h80,8'h00,8'h00,1'h0,8'h00,3'h5,2'h1},
    '{5'h05,8'h05,1'h1,8'h9A,8'h00,8'h9A,1'h1,8'h00,3'h5,2'h1}};

    // ------------------------------------------------------------------
    // design, far side, clock and watchdog
    // ------------------------------------------------------------------
    aamd_datapath aamd_datapath_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i), .y_i(y_i),
        .z_i(z_i), .rom_data_i(rom_data_i), .busy_o(busy_o),
        .rom_addr_o(rom_addr_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_b0_o(mem_b0_o),
        .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .r_o(r_o),
        .r_we_o(r_we_o), .flags_o(flags_o), .cycles_o(cycles_o),
        .done_o(done_o));
    aamd_mem_model aamd_mem_model_inst (.clk_i(clk_i), .busy_i(busy_o),
        .rom_addr_i(rom_addr_o), .mem_we_i(mem_we_o),
        .mem_addr_i(mem_addr_o), .mem_b0_i(mem_b0_o),
        .mem_wdata_i(mem_wdata_o), .rom_data_o(rom_data_i));
    // free running clock
    always #5 clk_i = ~clk_i;
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc_count++;
        if (cyc_count == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------------------------
    task check(input string name, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        rst_b_i = 1'h1;
        check("acc_reset", acc_o, 8'h00);
        check("flags_reset", flags_o, 3'h0);
        repeat (3) @(posedge clk_i);
        #1;
        // table rows issued back to back
        for (i = 0; i < 29; i++) begin
            req_i = '{aamd_pkg::aamd_op_e'(rows[i].op), rows[i].addr,
                      rows[i].b0, rows[i].mem, rows[i].lit};
            req_valid_i = 1'h1;
            @(posedge clk_i);
            #1;
            check("done", done_o, 1'h1);
            check("acc", acc_o, rows[i].acc);
            check("flags", flags_o, rows[i].fl);
            check("mem_we", mem_we_o, rows[i].we);
            if (rows[i].we) begin
                check("mem_addr", mem_addr_o, rows[i].addr);
                check("mem_b0", mem_b0_o, rows[i].b0);
                check("wdata", mem_wdata_o, rows[i].wd);
            end
            check("cycles", cycles_o, rows[i].cyc);
        end
        check("ram_87", aamd_mem_model_inst.ram[9'h187], 8'h33);
        // table read with a request offered while busy
        req_i = '{aamd_pkg::AAMD_OP_TABLE_READ, 8'h00, 1'h0, 8'h00, 8'h00};
        @(posedge clk_i);
        #1;
        check("busy", busy_o, 1'h1);
        req_i = '{aamd_pkg::AAMD_OP_ADD_AI, 8'h00, 1'h0, 8'h00, 8'h01};
        @(posedge clk_i);
        #1;
        req_valid_i = 1'h0;
        check("table_acc", acc_o, 8'h12 ^ 8'hC3);
        check("table_r", r_o, 8'h34 ^ 8'h5A);
        check("r_we", r_we_o, 1'h1);
        check("table_cycles", cycles_o, 2'h2);
        @(posedge clk_i);
        #1;
        check("busy_refused", acc_o, 8'h12 ^ 8'hC3);
        check("table_flags", flags_o, 3'h5);
        // clock enable low freezes the datapath
        ce_i = 1'h0;
        req_valid_i = 1'h1;
        @(posedge clk_i);
        #1;
        check("ce_done", done_o, 1'h0);
        req_valid_i = 1'h0;
        ce_i = 1'h1;
        @(posedge clk_i);
        #1;
        check("ce_acc", acc_o, 8'h12 ^ 8'hC3);
        // reset in mid run clears at once
        rst_b_i = 1'h0;
        #1;
        check("acc_rerst", acc_o, 8'h00);
        check("flags_rerst", flags_o, 3'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
